// *** design/i2c_trig_pkg.sv ***
// Constants, register map and encodings of the I2C trigger decoder.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
package i2c_trig_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam int ADR_W = 8;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_PAT_LO0 = 8'h08;
    localparam logic [7:0] OFS_PAT_LO1 = 8'h0C;
    localparam logic [7:0] OFS_PAT_HI0 = 8'h10;
    localparam logic [7:0] OFS_PAT_HI1 = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_FRAME = 8'h1C;
    localparam logic [7:0] OFS_FSTART = 8'h20;
    localparam logic [7:0] OFS_FADDR = 8'h24;
    localparam logic [7:0] OFS_RATE = 8'h28;
    localparam logic [7:0] OFS_BYTE = 8'h40;
    localparam logic [7:0] OFS_ACKT = 8'h60;
    // ----------------------------------------------------------------
    // Control fields
    // ----------------------------------------------------------------
    localparam int CTRL_MODE = 0;
    localparam int CTRL_W10 = 3;
    localparam int CTRL_DIR = 4;
    localparam int CTRL_NA_A = 6;
    localparam int CTRL_NA_W = 7;
    localparam int CTRL_NA_R = 8;
    localparam int CTRL_ACOND = 9;
    localparam int CTRL_DCOND = 11;
    localparam int CTRL_RUN = 13;
    localparam int CTRL_SKIP = 16;
    localparam int CTRL_LEN = 24;
    localparam logic [31:0] CTRL_RESET = 32'h0100_2000;
    localparam int ADDR_UPPER = 16;
    localparam int LOG_DEPTH = 8;
    localparam logic [4:0] TEN_BIT_PREFIX = 5'h1E;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_START = 3'h0, MODE_RSTART = 3'h1, MODE_STOP = 3'h2, MODE_NOACK = 3'h3,
        MODE_ADDR = 3'h4, MODE_DATA = 3'h5, MODE_ADDR_DATA = 3'h6
    } mode_t;
    typedef enum logic [1:0] {
        COND_EQUAL = 2'h0, COND_IN = 2'h1, COND_OUT = 2'h2
    } cond_t;
    typedef enum logic [1:0] {
        DIR_WRITE = 2'h0, DIR_READ = 2'h1, DIR_EITHER = 2'h2
    } dir_t;
    typedef enum logic [2:0] {
        ST_IDLE = 3'h1, ST_BITS = 3'h2, ST_ACK = 3'h4
    } fsm_t;
endpackage

// *** design/i2c_protocol_trigger_decoder.sv ***
// Passive I2C monitor: trigger generation and frame log, Wishbone slave.
// Assumes sda/scl are thresholded levels from outside the clock domain.
//
// Local design decisions: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module i2c_protocol_trigger_decoder #(
    parameter int TIME_W = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic sda,
    input wire logic scl,
    input wire logic wb_cyc,
    input wire logic wb_stb,
    input wire logic wb_we,
    input wire logic [i2c_trig_pkg::ADR_W-1:0] wb_adr,
    input wire logic [31:0] wb_dat_w,
    input wire logic [3:0] wb_sel,
    output logic [31:0] wb_dat_r,
    output logic wb_ack,
    output logic trigger,
    output logic frame_active
);
    import i2c_trig_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic sda_m, sda_s, sda_d, scl_m, scl_s, scl_d;
        fsm_t st;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic ack_low, ack_seen, busy;
        logic [3:0] byte_num;
        logic [7:0] data_idx;
        logic addr_done, addr_ok, data_ok, data_hit, pend10, is10, dir;
        logic [9:0] addr;
        logic [31:0] ctrl, addr_cfg;
        logic [63:0] pat_lo, pat_hi;
        logic [TIME_W-1:0] now, fstart, scl_last, rate;
        logic [15:0] findex, trig_cnt;
        logic incomplete;
        logic [LOG_DEPTH-1:0][8:0] blog;
        logic [LOG_DEPTH-1:0][TIME_W-1:0] tlog;
        logic trig, ack;
        logic [31:0] rdata;
    } regs_t;

    regs_t s, next_s;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic in_cond(input logic [9:0] v, input logic [9:0] lo,
                                     input logic [9:0] hi, input logic [1:0] c);
        logic inside_r;
        inside_r = (v >= lo) && (v <= hi);
        case (c)
            COND_EQUAL: in_cond = (v == lo);
            COND_IN: in_cond = inside_r;
            COND_OUT: in_cond = !inside_r;
            default: in_cond = 1'h0;
        endcase
    endfunction

    // Byte k of an msb-first pattern of len bytes
    function automatic logic [7:0] pat_byte(input logic [63:0] p, input logic [3:0] len,
                                            input logic [7:0] k);
        logic [5:0] sh;
        sh = {3'(len - 4'h1 - k[3:0]), 3'h0};
        pat_byte = 8'(p >> sh);
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
        merge = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                merge[i*8 +: 8] = d[i*8 +: 8];
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Decoded configuration and line events
    // ----------------------------------------------------------------
    logic [2:0] mode;
    logic w10, scl_hi, scl_rise, scl_fall, start_ev, stop_ev, ack_done, nack;
    logic [1:0] dir_sel;
    logic [3:0] pat_len;
    logic [7:0] skip;
    assign mode = s.ctrl[CTRL_MODE +: 3];
    assign w10 = s.ctrl[CTRL_W10];
    assign dir_sel = s.ctrl[CTRL_DIR +: 2];
    assign skip = s.ctrl[CTRL_SKIP +: 8];
    // A zero length would never complete; treat it as one byte
    assign pat_len = (s.ctrl[CTRL_LEN +: 4] == 4'h0) ? 4'h1 :
                     (s.ctrl[CTRL_LEN +: 4] > 4'h8) ? 4'h8 : s.ctrl[CTRL_LEN +: 4];
    assign scl_hi = s.scl_s && s.scl_d;
    assign scl_rise = s.scl_s && !s.scl_d;
    assign scl_fall = !s.scl_s && s.scl_d;
    assign start_ev = scl_hi && s.sda_d && !s.sda_s;
    assign stop_ev = scl_hi && !s.sda_d && s.sda_s;
    assign ack_done = (s.st == ST_ACK) && scl_fall && s.ack_seen;
    assign nack = !s.ack_low;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic addr_fin, a_ok, b_ok, dir_ok;
        logic [9:0] a_val;
        logic [7:0] rel;
        logic [2:0] li;
        logic [31:0] new_ctrl;
        next_s = s;
        addr_fin = 1'h0;
        a_ok = 1'h0;
        b_ok = 1'h0;
        dir_ok = 1'h0;
        a_val = s.addr;
        rel = s.data_idx - skip;
        li = s.byte_num[2:0];
        new_ctrl = s.ctrl;
        next_s.trig = 1'h0;
        next_s.ack = 1'h0;
        // Two-stage synchronisers, then one registered sample for edges
        next_s.sda_m = sda;
        next_s.sda_s = s.sda_m;
        next_s.sda_d = s.sda_s;
        next_s.scl_m = scl;
        next_s.scl_s = s.scl_m;
        next_s.scl_d = s.scl_s;
        next_s.now = s.now + 1'h1;
        if (scl_rise) begin
            next_s.rate = s.now - s.scl_last;
            next_s.scl_last = s.now;
        end
        if (start_ev) begin
            // A start while busy closes the open frame and opens a new one
            if (mode == MODE_START || (mode == MODE_RSTART && s.busy)) begin
                next_s.trig = 1'h1;
            end
            next_s.busy = 1'h1;
            next_s.st = ST_BITS;
            next_s.bit_cnt = 4'h0;
            next_s.byte_num = 4'h0;
            next_s.data_idx = 8'h00;
            next_s.addr_done = 1'h0;
            next_s.addr_ok = 1'h0;
            next_s.data_ok = 1'h1;
            next_s.data_hit = 1'h0;
            next_s.pend10 = 1'h0;
            next_s.is10 = 1'h0;
            next_s.incomplete = 1'h0;
            next_s.findex = s.findex + 16'h1;
            next_s.fstart = s.now;
        end else if (stop_ev) begin
            if (mode == MODE_STOP) begin
                next_s.trig = 1'h1;
            end
            next_s.busy = 1'h0;
            next_s.st = ST_IDLE;
        end else begin
            case (s.st)
                ST_IDLE: begin
                    next_s.st = ST_IDLE;
                end
                ST_BITS: begin
                    if (scl_rise) begin
                        next_s.shift = {s.shift[6:0], s.sda_s};
                        next_s.bit_cnt = s.bit_cnt + 4'h1;
                    end
                    if (scl_fall && s.bit_cnt == BITS_PER_BYTE) begin
                        next_s.st = ST_ACK;
                        next_s.ack_low = 1'h0;
                        next_s.ack_seen = 1'h0;
                        if (s.ctrl[CTRL_RUN] && !s.byte_num[3]) begin
                            next_s.tlog[li] = s.now;
                        end
                    end
                end
                ST_ACK: begin
                    if (s.scl_s && !s.sda_s) begin
                        next_s.ack_low = 1'h1;
                    end
                    if (scl_rise) begin
                        next_s.ack_seen = 1'h1;
                    end
                    if (ack_done) begin
                        next_s.st = ST_BITS;
                        next_s.bit_cnt = 4'h0;
                        if (s.byte_num != 4'hF) begin
                            next_s.byte_num = s.byte_num + 4'h1;
                        end
                        if (s.ctrl[CTRL_RUN] && !s.byte_num[3]) begin
                            next_s.blog[li] = {nack, s.shift};
                        end
                        if (!s.addr_done) begin
                            if (mode == MODE_NOACK && nack && s.ctrl[CTRL_NA_A]) begin
                                next_s.trig = 1'h1;
                            end
                            if (s.pend10) begin
                                next_s.addr[7:0] = s.shift;
                                next_s.pend10 = 1'h0;
                                addr_fin = 1'h1;
                            end else if (w10 && s.shift[7:3] == TEN_BIT_PREFIX) begin
                                next_s.is10 = 1'h1;
                                next_s.addr[9:8] = s.shift[2:1];
                                next_s.dir = s.shift[0];
                                // Read form repeats only the upper bits; low byte kept
                                next_s.pend10 = !s.shift[0];
                                addr_fin = s.shift[0];
                            end else begin
                                next_s.addr = {3'h0, s.shift[7:1]};
                                next_s.dir = s.shift[0];
                                addr_fin = 1'h1;
                            end
                        end else begin
                            if (mode == MODE_NOACK && nack &&
                                ((!s.dir && s.ctrl[CTRL_NA_W]) ||
                                 (s.dir && s.ctrl[CTRL_NA_R]))) begin
                                next_s.trig = 1'h1;
                            end
                            if (s.data_idx >= skip && rel < 8'(pat_len) && s.data_ok) begin
                                b_ok = in_cond({2'h0, s.shift},
                                               {2'h0, pat_byte(s.pat_lo, pat_len, rel)},
                                               {2'h0, pat_byte(s.pat_hi, pat_len, rel)},
                                               s.ctrl[CTRL_DCOND +: 2]);
                                next_s.data_ok = b_ok;
                                if (b_ok && rel == 8'(pat_len - 4'h1)) begin
                                    next_s.data_hit = 1'h1;
                                    if (mode == MODE_DATA ||
                                        (mode == MODE_ADDR_DATA && s.addr_ok)) begin
                                        next_s.trig = 1'h1;
                                    end
                                end
                            end
                            if (s.data_idx != 8'hFF) begin
                                next_s.data_idx = s.data_idx + 8'h01;
                            end
                        end
                    end
                end
                default: begin
                    next_s.st = ST_IDLE;
                end
            endcase
        end
        if (addr_fin) begin
            next_s.addr_done = 1'h1;
            a_val = next_s.addr;
            dir_ok = (dir_sel == DIR_EITHER) ||
                     (dir_sel == DIR_READ && next_s.dir) ||
                     (dir_sel == DIR_WRITE && !next_s.dir);
            // Seven-bit mode masks the pattern to seven bits
            a_ok = (next_s.is10 == w10) && dir_ok &&
                   in_cond(a_val, w10 ? s.addr_cfg[9:0] : {3'h0, s.addr_cfg[6:0]},
                           w10 ? s.addr_cfg[ADDR_UPPER +: 10] :
                                 {3'h0, s.addr_cfg[ADDR_UPPER +: 7]},
                           s.ctrl[CTRL_ACOND +: 2]);
            next_s.addr_ok = a_ok;
            if (mode == MODE_ADDR && a_ok) begin
                next_s.trig = 1'h1;
            end
        end
        if (next_s.trig) begin
            next_s.trig_cnt = s.trig_cnt + 16'h1;
        end
        // Wishbone slave: ack one cycle after request, write at acked edge
        if (wb_cyc && wb_stb && !s.ack) begin
            next_s.ack = 1'h1;
            next_s.rdata = 32'h0;
            if (wb_adr[7:5] == OFS_BYTE[7:5]) begin
                next_s.rdata = {23'h0, s.blog[wb_adr[4:2]]};
            end else if (wb_adr[7:5] == OFS_ACKT[7:5]) begin
                next_s.rdata = 32'(s.tlog[wb_adr[4:2]]);
            end else begin
                case (wb_adr)
                    OFS_CTRL: next_s.rdata = s.ctrl;
                    OFS_ADDR: next_s.rdata = s.addr_cfg;
                    OFS_PAT_LO0: next_s.rdata = s.pat_lo[31:0];
                    OFS_PAT_LO1: next_s.rdata = s.pat_lo[63:32];
                    OFS_PAT_HI0: next_s.rdata = s.pat_hi[31:0];
                    OFS_PAT_HI1: next_s.rdata = s.pat_hi[63:32];
                    OFS_STATUS: next_s.rdata = {14'h0, s.data_hit, s.busy, s.trig_cnt};
                    OFS_FRAME: next_s.rdata = {12'h0, s.incomplete, s.addr_ok, s.dir,
                                               s.is10, s.findex};
                    OFS_FSTART: next_s.rdata = 32'(s.fstart);
                    OFS_FADDR: next_s.rdata = {22'h0, s.addr};
                    OFS_RATE: next_s.rdata = 32'(s.rate);
                    default: next_s.rdata = 32'h0;
                endcase
            end
        end
        if (s.ack && wb_cyc && wb_stb && wb_we) begin
            case (wb_adr)
                OFS_CTRL: begin
                    new_ctrl = merge(s.ctrl, wb_dat_w, wb_sel);
                    next_s.ctrl = new_ctrl;
                    if (s.busy && s.ctrl[CTRL_RUN] && !new_ctrl[CTRL_RUN]) begin
                        next_s.incomplete = 1'h1;
                    end
                end
                OFS_ADDR: next_s.addr_cfg = merge(s.addr_cfg, wb_dat_w, wb_sel);
                OFS_PAT_LO0: next_s.pat_lo[31:0] = merge(s.pat_lo[31:0], wb_dat_w, wb_sel);
                OFS_PAT_LO1: next_s.pat_lo[63:32] = merge(s.pat_lo[63:32], wb_dat_w, wb_sel);
                OFS_PAT_HI0: next_s.pat_hi[31:0] = merge(s.pat_hi[31:0], wb_dat_w, wb_sel);
                OFS_PAT_HI1: next_s.pat_hi[63:32] = merge(s.pat_hi[63:32], wb_dat_w, wb_sel);
                default: next_s.ctrl = s.ctrl;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
            s.ctrl <= CTRL_RESET;
            s.st <= ST_IDLE;
            s.data_ok <= 1'h1;
            // Idle-high lines, so release gives no false edge
            s.sda_m <= 1'h1;
            s.sda_s <= 1'h1;
            s.sda_d <= 1'h1;
            s.scl_m <= 1'h1;
            s.scl_s <= 1'h1;
            s.scl_d <= 1'h1;
        end else begin
            s <= next_s;
        end
    end

    assign wb_dat_r = s.rdata;
    assign wb_ack = s.ack;
    assign trigger = s.trig;
    assign frame_active = s.busy;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    start_trig_a: assert property (start_ev && mode == MODE_START |=> trigger)
        else $error("start did not trigger");
    rstart_idle_a: assert property (start_ev && mode == MODE_RSTART && !s.busy |=> !trigger)
        else $error("repeated start fired on idle bus");
    stop_trig_a: assert property (stop_ev && mode == MODE_STOP |=> trigger ##1 !trigger)
        else $error("stop trigger wrong");
    noack_time_a: assert property (trigger && mode == MODE_NOACK |-> $past(ack_done))
        else $error("no-ack trigger off the ack slot");
    read_nack_a: assert property (ack_done && s.addr_done && s.dir && mode == MODE_NOACK
        && !s.ctrl[CTRL_NA_R] |=> !trigger)
        else $error("read no-ack reported while disabled");
    addr_time_a: assert property (trigger && mode == MODE_ADDR |-> $past(ack_done)
        && s.addr_ok && s.addr_done)
        else $error("address trigger at wrong moment");
    addr_width_a: assert property ($rose(s.addr_ok) |-> s.is10 == w10)
        else $error("address matched in wrong width");
    dir_qual_a: assert property ($rose(s.addr_ok) && dir_sel == DIR_READ |-> s.dir)
        else $error("read-only match on write");
    combo_need_a: assert property (trigger && mode == MODE_ADDR_DATA |-> s.addr_ok
        && s.data_hit)
        else $error("combined trigger without both");
    trig_pulse_a: assert property (trigger |=> !trigger)
        else $error("trigger wider than one cycle");
    ack_drop_a: assert property (wb_ack |=> !wb_ack)
        else $error("bus ack held");

    start_cov_c: cover property (start_ev && mode == MODE_START ##1 trigger);
    addr_cov_c: cover property (ack_done && mode == MODE_ADDR ##1 trigger);
    data_cov_c: cover property (s.data_hit && mode == MODE_ADDR_DATA && trigger);
    nack_cov_c: cover property (ack_done && nack ##1 trigger);
endmodule

// *** sim/i2c_bus_model.sv ***
// Behavioural I2C controller plus target, driving both bus lines.
// Assumes open-drain lines with pull-ups, so idle is high.
`timescale 1ns/1ps
module i2c_bus_model (
    input wire logic clk_sys,
    output logic sda,
    output logic scl
);
    initial begin
        sda = 1'b1;
        scl = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // --------------------------------------------------------------
    // Conditions: SDA moves with SCL low, except start and stop
    // --------------------------------------------------------------
    task automatic start_cond(input logic rep);
        if (rep) begin
            scl <= 1'b0;
            hold(2);
            sda <= 1'b1;
            hold(2);
            scl <= 1'b1;
            hold(4);
        end
        sda <= 1'b0;
        hold(4);
        scl <= 1'b0;
        hold(2);
    endtask
    task automatic stop_cond();
        scl <= 1'b0;
        hold(2);
        sda <= 1'b0;
        hold(2);
        scl <= 1'b1;
        hold(4);
        sda <= 1'b1;
        hold(4);
    endtask
    // One SCL period is 8 clocks, 320 ns
    task automatic put_bit(input logic v);
        scl <= 1'b0;
        hold(2);
        sda <= v;
        hold(2);
        scl <= 1'b1;
        hold(4);
    endtask
    // Byte msb first, then the receiver's ack level (1 is no ack)
    task automatic xfer(input logic [7:0] b, input logic ack);
        for (int i = 7; i >= 0; i--) put_bit(b[i]);
        put_bit(ack);
    endtask
endmodule

// *** sim/tb_i2c_protocol_trigger_decoder.sv ***
// Self-checking bench: Wishbone set-up, I2C frames, trigger counting.
// Assumes the decoder and the bus model compile before this file.
`timescale 1ns/1ps
module tb_i2c_protocol_trigger_decoder;
    import i2c_trig_pkg::*;
    typedef struct packed {
        logic [11:0] m;
        logic [7:0] b0;
        logic [7:0] b1;
        logic a0;
        logic rs;
        logic [1:0] n;
    } case_t;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [ADR_W-1:0] wb_adr = '0;
    logic [31:0] wb_dat_w = '0;
    logic [3:0] wb_sel = 4'hF;
    logic [31:0] wb_dat_r, rd;
    logic wb_ack, trigger, frame_active, sda, scl;
    int failures = 0;
    int cmp_count = 0;
    int trig_n = 0;
    int exp_trig = 0;
    int base;
    // Control bits, address byte, second byte, address ack, repeated start, pulses
    case_t tc [12] = '{
        '{12'h000, 8'hB6, 8'h11, 1'b0, 1'b0, 2'h1},
        '{12'h001, 8'hB6, 8'hB7, 1'b0, 1'b1, 2'h1},
        '{12'h001, 8'hB6, 8'h11, 1'b0, 1'b0, 2'h0},
        '{12'h002, 8'hB6, 8'h11, 1'b0, 1'b0, 2'h1},
        '{12'h004, 8'hB6, 8'h11, 1'b0, 1'b0, 2'h1},
        '{12'h014, 8'hB6, 8'h11, 1'b0, 1'b0, 2'h0},
        '{12'h043, 8'hB6, 8'h11, 1'b1, 1'b0, 2'h1},
        '{12'h003, 8'hB6, 8'h11, 1'b1, 1'b0, 2'h0},
        '{12'h00C, 8'hF0, 8'h5B, 1'b0, 1'b0, 2'h1},
        '{12'h006, 8'hB6, 8'h75, 1'b0, 1'b0, 2'h1},
        '{12'h005, 8'hB6, 8'h75, 1'b0, 1'b0, 2'h1},
        '{12'h005, 8'hB6, 8'h74, 1'b0, 1'b0, 2'h0}};
    i2c_protocol_trigger_decoder i2c_protocol_trigger_decoder_inst (.clk_sys(clk_sys),
        .rst(rst), .sda(sda), .scl(scl), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_dat_w(wb_dat_w), .wb_sel(wb_sel), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .trigger(trigger), .frame_active(frame_active));
    i2c_bus_model i2c_bus_model_inst (.clk_sys(clk_sys), .sda(sda), .scl(scl));
    always #20 clk_sys = ~clk_sys;
    // Counting high cycles means a stretched pulse shows as an extra trigger
    always @(posedge clk_sys) if (trigger === 1'b1) trig_n <= trig_n + 1;
    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int t = 0;
        @(posedge clk_sys);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_dat_w <= d;
        do begin
            @(posedge clk_sys);
            t++;
        end while (wb_ack !== 1'b1 && t < 50);
        if (t >= 50) failures++;
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // --------------------------------------------------------------
    // Sequence
    // --------------------------------------------------------------
    initial begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        wb(1'b0, OFS_CTRL, '0);
        check("ctrl reset", CTRL_RESET, rd);
        wb(1'b0, 8'hFC, '0);
        check("unmapped read", 32'h0, rd);
        wb(1'b1, OFS_ADDR, 32'h5B);
        wb(1'b1, OFS_PAT_LO0, 32'h75);
        foreach (tc[i]) begin
            wb(1'b1, OFS_CTRL, CTRL_RESET | {20'h0, tc[i].m});
            base = trig_n;
            exp_trig += tc[i].n;
            i2c_bus_model_inst.start_cond(1'b0);
            i2c_bus_model_inst.xfer(tc[i].b0, tc[i].a0);
            if (tc[i].rs) i2c_bus_model_inst.start_cond(1'b1);
            i2c_bus_model_inst.xfer(tc[i].b1, 1'b0);
            i2c_bus_model_inst.stop_cond();
            repeat (10) @(posedge clk_sys);
            check("trigger pulses", {30'h0, tc[i].n}, 32'(trig_n - base));
        end
        wb(1'b0, OFS_FADDR, '0);
        check("frame address", 32'h5B, rd);
        wb(1'b0, OFS_FRAME, '0);
        check("frame dir", 32'h0, {31'h0, rd[17]});
        wb(1'b0, OFS_BYTE + 8'h04, '0);
        check("byte log", 32'h74, {23'h0, rd[8:0]});
        wb(1'b0, OFS_STATUS, '0);
        check("trigger count", 32'(exp_trig), {16'h0, rd[15:0]});
        wb(1'b0, OFS_RATE, '0);
        check("bit rate", 32'h8, rd);
        // Cut a frame: capture stops while the bus is still busy
        i2c_bus_model_inst.start_cond(1'b0);
        check("frame active", 32'h1, {31'h0, frame_active});
        wb(1'b1, OFS_CTRL, 32'h0);
        wb(1'b0, OFS_FRAME, '0);
        check("incomplete", 32'h1, {31'h0, rd[19]});
        i2c_bus_model_inst.stop_cond();
        repeat (10) @(posedge clk_sys);
        check("frame idle", 32'h0, {31'h0, frame_active});
        tally_and_finish();
    end
    initial begin
        #1_000_000;
        failures++;
        tally_and_finish();
    end
endmodule
